// file: sasr_core.sv
`timescale 1ns/1ps
module sasr_core (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Converter pins
  input  wire logic                          convert_start,
  input  wire logic                          chain_select,
  input  wire logic                          read_enable_or_chain_input,
  input  wire logic                          sck,
  output logic                               sdo,
  output logic                               sdo_oe,
  output logic                               busy,
  output logic                               nap,
  // Sampled analog level, offset binary, stable during acquisition
  input  wire logic [sasr_pkg::RESULT_W-1:0] analog_sample,
  // Interrupt
  output logic                               irq
);
  localparam int W = sasr_pkg::RESULT_W;
  localparam int P = sasr_pkg::PIN_N;

  typedef struct packed {
    logic [P-1:0]                sy1;
    logic [P-1:0]                sy2;
    logic [P-1:0]                sy3;
    logic [P-1:0]                filt;
    sasr_pkg::sasr_state_t       st;
    logic                        busy;
    logic [W-1:0]                shreg;
    logic [sasr_pkg::IDX_W-1:0]  shcnt;
    logic [W-1:0]                result;
    logic                        ctrl_en;
    logic [sasr_pkg::IRQ_W-1:0]  irq_stat;
    logic [sasr_pkg::IRQ_W-1:0]  irq_mask;
    logic [31:0]                 prdata;
    logic                        pslverr;
    logic                        sdo;
    logic                        sdo_oe;
  } sasr_core_st_t;

  sasr_core_st_t s;
  sasr_core_st_t n;

  logic [P-1:0]                pins;
  logic [P-1:0]                filt_nxt;
  logic [P-1:0]                rise;
  logic                        chain_mode;
  logic                        out_en;
  logic                        out_en_nxt;
  logic                        sck_rise;
  logic                        start_req;
  logic                        overrun;
  logic                        ev_done;
  logic                        ev_read;
  logic                        setup;
  logic                        wr;
  logic [sasr_pkg::IRQ_W-1:0]  irq_ev;
  logic [sasr_pkg::IRQ_W-1:0]  irq_clr;

  sasr_sar_if sar_c ();

  sasr_sar_engine u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .sar     (sar_c.engine)
  );

  assign pins = {chain_select, read_enable_or_chain_input, sck, convert_start};

  // A pin level counts only once the second and third stages agree
  assign filt_nxt   = (~(s.sy2 ^ s.sy3) & s.sy3) | ((s.sy2 ^ s.sy3) & s.filt);
  assign rise       = filt_nxt & ~s.filt;
  assign chain_mode = s.filt[sasr_pkg::PIN_CHAIN];
  // Chain mode leaves the output on; normal mode enables it while the pin is low
  assign out_en     = chain_mode | ~s.filt[sasr_pkg::PIN_REN];
  assign out_en_nxt = filt_nxt[sasr_pkg::PIN_CHAIN] | ~filt_nxt[sasr_pkg::PIN_REN];
  assign sck_rise   = rise[sasr_pkg::PIN_SCK];
  // Starts during a conversion are dropped and flagged as overrun
  assign start_req  = rise[sasr_pkg::PIN_CONV] & s.ctrl_en & (s.st == sasr_pkg::SASR_ACQ);
  assign overrun    = rise[sasr_pkg::PIN_CONV] & (s.st == sasr_pkg::SASR_CONV);
  assign ev_done    = (s.st == sasr_pkg::SASR_CONV) & sar_c.done;
  assign ev_read    = (s.st == sasr_pkg::SASR_ACQ) & sck_rise & out_en &
                      (s.shcnt == sasr_pkg::SH_FULL - 5'h1);

  assign sar_c.start  = start_req;
  assign sar_c.sample = analog_sample;

  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign irq_ev  = {overrun, ev_read, ev_done};
  assign irq_clr = (wr && paddr == sasr_pkg::OFF_IRQ_STAT) ?
                   pwdata[sasr_pkg::IRQ_W-1:0] : '0;

  always_comb begin
    n      = s;
    n.sy1  = pins;
    n.sy2  = s.sy1;
    n.sy3  = s.sy2;
    n.filt = filt_nxt;

    unique case (s.st)
      sasr_pkg::SASR_ACQ: begin
        if (start_req) begin
          n.st   = sasr_pkg::SASR_CONV;
          n.busy = 1'b1;
        end else if (sck_rise && out_en) begin
          // Chained data enters behind our own bits and follows them out
          n.shreg = {s.shreg[W-2:0], chain_mode & filt_nxt[sasr_pkg::PIN_REN]};
          if (s.shcnt != sasr_pkg::SH_FULL) begin
            n.shcnt = s.shcnt + 5'h1;
          end
        end
      end
      sasr_pkg::SASR_CONV: begin
        if (sar_c.done) begin
          n.st     = sasr_pkg::SASR_ACQ;
          n.busy   = 1'b0;
          n.result = sar_c.code;
          n.shreg  = sar_c.code;
          n.shcnt  = '0;
        end
      end
    endcase

    n.sdo    = n.shreg[W-1];
    n.sdo_oe = out_en_nxt;

    // Hardware set wins over a software clear in the same cycle
    n.irq_stat = (s.irq_stat & ~irq_clr) | irq_ev;
    if (wr && paddr == sasr_pkg::OFF_CTRL) begin
      n.ctrl_en = pwdata[sasr_pkg::CTRL_EN_BIT];
    end
    if (wr && paddr == sasr_pkg::OFF_IRQ_MASK) begin
      n.irq_mask = pwdata[sasr_pkg::IRQ_W-1:0];
    end

    // Read data is latched in the setup phase, so pready never waits
    if (setup) begin
      n.prdata  = '0;
      n.pslverr = 1'b0;
      unique case (paddr)
        sasr_pkg::OFF_CTRL: begin
          n.prdata[sasr_pkg::CTRL_EN_BIT] = s.ctrl_en;
        end
        sasr_pkg::OFF_STATUS: begin
          n.prdata[sasr_pkg::ST_BUSY_BIT]  = s.busy;
          n.prdata[sasr_pkg::ST_NAP_BIT]   = (s.st == sasr_pkg::SASR_ACQ);
          n.prdata[sasr_pkg::ST_CHAIN_BIT] = chain_mode;
          n.prdata[sasr_pkg::ST_CNT_LSB +: sasr_pkg::IDX_W] = s.shcnt;
        end
        sasr_pkg::OFF_RESULT: begin
          n.prdata[W-1:0] = s.result;
        end
        sasr_pkg::OFF_IRQ_STAT: begin
          n.prdata[sasr_pkg::IRQ_W-1:0] = s.irq_stat;
        end
        sasr_pkg::OFF_IRQ_MASK: begin
          n.prdata[sasr_pkg::IRQ_W-1:0] = s.irq_mask;
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.sdo_oe   <= 1'b1;
      s.ctrl_en  <= sasr_pkg::CTRL_EN_RST;
      s.irq_mask <= sasr_pkg::IRQ_MASK_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = 1'b1;
  assign pslverr = s.pslverr & psel & penable;
  assign sdo     = s.sdo;
  assign sdo_oe  = s.sdo_oe;
  assign busy    = s.busy;
  assign nap     = (s.st == sasr_pkg::SASR_ACQ);
  assign irq     = |(s.irq_stat & s.irq_mask);

  chk_start_raises_busy: assert property (@(posedge pclk) disable iff (!presetn)
    start_req |=> (s.busy && !nap))
    else $error("start did not raise busy");

  chk_conv_internal_time: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.busy) |-> s.busy[*8] ##11 s.busy ##1 !s.busy)
    else $error("conversion length is not 19 cycles");

  chk_result_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(s.busy) |-> (s.shreg == s.result && s.shcnt == '0 && s.sdo == s.result[W-1]))
    else $error("result not ready when busy fell");

  chk_nap_between: assert property (@(posedge pclk) disable iff (!presetn)
    ev_done |=> (nap && !s.busy))
    else $error("no nap after conversion");

  chk_normal_oe: assert property (@(posedge pclk) disable iff (!presetn)
    !chain_mode |-> (s.sdo_oe == !s.filt[sasr_pkg::PIN_REN]))
    else $error("normal mode output enable wrong");

  chk_chain_oe: assert property (@(posedge pclk) disable iff (!presetn)
    chain_mode |-> s.sdo_oe)
    else $error("chain mode output not enabled");

  chk_shift_msb_first: assert property (@(posedge pclk) disable iff (!presetn)
    (sck_rise && out_en && s.st == sasr_pkg::SASR_ACQ && !start_req)
      |=> (s.sdo == $past(s.shreg[W-2]) && s.shreg[W-1:1] == $past(s.shreg[W-2:0])))
    else $error("serial shift wrong");

  chk_hold_no_clock: assert property (@(posedge pclk) disable iff (!presetn)
    (!sck_rise && !sar_c.done) |=> $stable(s.sdo))
    else $error("output moved without clock edge");

  chk_chain_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (chain_mode && sck_rise && s.st == sasr_pkg::SASR_ACQ && !start_req)
      |=> s.shreg[0] == $past(filt_nxt[sasr_pkg::PIN_REN]))
    else $error("chain input bit not taken");

  chk_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ev_done |=> s.irq_stat[sasr_pkg::IRQ_DONE_BIT])
    else $error("done flag not set");
endmodule : sasr_core

// file: sasr_pkg.sv
// Function
// - A convert_start rising edge wakes the device and starts a new conversion.
// - Acquisition tracks the input; a convert_start rising edge begins conversion.
// - Conversion resolves 18 bits by successive approximation, down to 1/262144.
// - Conversion is timed internally; no host clock edges drive it.
// - Busy rises when a conversion starts and falls when it ends.
// - After conversion an 18-bit code is prepared and held for transfer.
// - The bipolar span maps onto 2^18 levels in two's complement form.
// - The newest result is ready in its own cycle at 1Msps throughput.
// - The device naps between conversions.
// - Chain select low: the shared pin enables or disables serial output.
// - Chain select high: the shared pin takes serial data from another converter.
// - Enabled output shifts own result or chained data MSB first on clock rise.
// - Serial output updates on a rising serial clock edge while enabled and not converting, and when a finished conversion loads the new result.
package sasr_pkg;
  localparam int RESULT_W      = 18;
  localparam int IDX_W         = 5;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYCLE_TIME_NS = 1000;
  localparam int CYCLE_CYC     = CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [IDX_W-1:0] SH_FULL = 5'h12;

  // Pin positions in the synchroniser vectors
  localparam int PIN_CONV  = 0;
  localparam int PIN_SCK   = 1;
  localparam int PIN_REN   = 2;
  localparam int PIN_CHAIN = 3;
  localparam int PIN_N     = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_RESULT   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

  // Field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_NAP_BIT   = 1;
  localparam int ST_CHAIN_BIT = 2;
  localparam int ST_CNT_LSB   = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_READ_BIT = 1;
  localparam int IRQ_OVR_BIT  = 2;
  localparam int IRQ_W        = 3;

  // Reset values
  localparam logic             CTRL_EN_RST  = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic [0:0] {
    SASR_ACQ  = 1'b0,
    SASR_CONV = 1'b1
  } sasr_state_t;
endpackage : sasr_pkg

// file: sasr_sar_if.sv
`timescale 1ns/1ps
interface sasr_sar_if;
  logic                          start;
  logic [sasr_pkg::RESULT_W-1:0] sample;
  logic                          done;
  logic [sasr_pkg::RESULT_W-1:0] code;
  logic                          busy;
  modport ctrl   (output start, output sample, input done, input code, input busy);
  modport engine (input start, input sample, output done, output code, output busy);
endinterface : sasr_sar_if

// file: sasr_sar_engine.sv
`timescale 1ns/1ps
module sasr_sar_engine (
  // Clock and reset
  input wire logic   pclk,
  input wire logic   presetn,
  // Control side
  sasr_sar_if.engine sar
);
  localparam int W = sasr_pkg::RESULT_W;

  typedef struct packed {
    logic                          active;
    logic [W-1:0]                  held;
    logic [W-1:0]                  acc;
    logic [sasr_pkg::IDX_W-1:0]    idx;
    logic                          done;
    logic [W-1:0]                  code;
  } sasr_eng_st_t;

  sasr_eng_st_t s;
  sasr_eng_st_t n;
  logic [W-1:0] weight;
  logic [W-1:0] trial;
  logic [W-1:0] acc_new;

  always_comb begin
    n       = s;
    n.done  = 1'b0;
    weight  = W'(1) << s.idx;
    trial   = s.acc | weight;
    // Keep the trial bit while the held sample is not below it
    acc_new = (s.held >= trial) ? trial : s.acc;
    if (sar.start && !s.active) begin
      n.active = 1'b1;
      n.held   = sar.sample;
      n.acc    = '0;
      n.idx    = sasr_pkg::IDX_W'(W - 1);
    end else if (s.active) begin
      n.acc = acc_new;
      if (s.idx == '0) begin
        n.active = 1'b0;
        n.done   = 1'b1;
        // Offset binary to two's complement by inverting the sign bit
        n.code   = {~acc_new[W-1], acc_new[W-2:0]};
      end else begin
        n.idx = s.idx - 5'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sar.done = s.done;
  assign sar.code = s.code;
  assign sar.busy = s.active;

  chk_sar_exact_code: assert property (@(posedge pclk) disable iff (!presetn)
    s.done |-> s.code == {~s.held[W-1], s.held[W-2:0]})
    else $error("result differs from held sample");

  chk_sar_step_count: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(s.active) |-> ##17 s.active ##1 (!s.active && s.done))
    else $error("search did not take one step per bit");
endmodule : sasr_sar_engine

// file: sasr_host_model.sv
`timescale 1ns/1ps
module sasr_host_model (
  // Clock
  input  wire logic pclk,
  // Converter pins
  output logic      convert_start,
  output logic      sck,
  output logic      read_enable_or_chain_input,
  input  wire logic sdo
);
  initial begin
    convert_start              = 1'b0;
    sck                        = 1'b0;
    read_enable_or_chain_input = 1'b1;
  end

  // Held four clocks: a pulse under two clocks never shows in two sync stages at once
  task automatic start_conv();
    @(posedge pclk);
    convert_start <= 1'b1;
    repeat (4) @(posedge pclk);
    convert_start <= 1'b0;
  endtask : start_conv

  task automatic set_pin(input logic v);
    @(posedge pclk);
    read_enable_or_chain_input <= v;
  endtask : set_pin

  // Samples before each rise; sck rests low between frames
  task automatic shift(input int n, input logic [31:0] cin, output logic [31:0] q);
    q = 32'h0;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge pclk);
      q = {q[30:0], sdo};
      read_enable_or_chain_input <= cin[i];
      sck <= 1'b1;
      repeat (4) @(posedge pclk);
      sck <= 1'b0;
    end
  endtask : shift
endmodule : sasr_host_model

// file: test_sar_adc_serial_readout.sv
`timescale 1ns/1ps
module test_sar_adc_serial_readout;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, q;
  logic        convert_start, chain_select, read_enable_or_chain_input;
  logic        sck, sdo, sdo_oe, busy, nap, irq, er;
  logic [17:0] analog_sample;
  int          n_errors = 0;
  int          checks = 0;

  sasr_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convert_start(convert_start), .chain_select(chain_select),
    .read_enable_or_chain_input(read_enable_or_chain_input), .sck(sck), .sdo(sdo),
    .sdo_oe(sdo_oe), .busy(busy), .nap(nap), .analog_sample(analog_sample), .irq(irq));

  sasr_host_model i_host (.pclk(pclk), .convert_start(convert_start), .sck(sck),
    .read_enable_or_chain_input(read_enable_or_chain_input), .sdo(sdo));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic conv(input logic [17:0] a);
    int n;
    n = 0;
    @(posedge pclk);
    analog_sample <= a;
    i_host.start_conv();
    while (busy !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      chk({31'h0, nap}, 32'h0);
      n++;
      @(posedge pclk);
    end
    chk(n, 32'd19);
    chk({31'h0, sdo}, {31'h0, ~a[17]});
  endtask : conv

  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_regs

  task automatic t_convert();
    conv(18'h2a5c3);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0a5c3);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h0c, 32'h7);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask : t_convert

  task automatic t_normal();
    i_host.set_pin(1'b0);
    conv(18'h1f00f);
    repeat (6) @(posedge pclk);
    chk({31'h0, sdo_oe}, 32'h1);
    i_host.shift(18, 32'h0, q);
    chk(q, 32'h3f00f);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk({27'h0, rd[12:8]}, 32'h12);
    i_host.set_pin(1'b1);
    repeat (6) @(posedge pclk);
    chk({31'h0, sdo_oe}, 32'h0);
  endtask : t_normal

  task automatic t_chain();
    @(posedge pclk);
    chain_select <= 1'b1;
    repeat (6) @(posedge pclk);
    conv(18'h00001);
    i_host.shift(22, 32'h0000000d, q);
    chk(q, {10'h0, 18'h20001, 4'hb});
    chain_select <= 1'b0;
  endtask : t_chain

  task automatic t_refuse();
    i_host.start_conv();
    repeat (8) @(posedge pclk);
    i_host.start_conv();
    repeat (30) @(posedge pclk);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    apb(1'b1, 8'h0c, 32'h7);
    apb(1'b1, 8'h00, 32'h0);
    i_host.start_conv();
    repeat (10) @(posedge pclk);
    chk({31'h0, busy}, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
  endtask : t_refuse

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chain_select = 1'b0;
    analog_sample = 18'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_convert();
    t_normal();
    t_chain();
    t_refuse();
    print_verdict();
  end

  // A hang counts as a failure and still ends the run the normal way
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    print_verdict();
  end
endmodule : test_sar_adc_serial_readout
